// >>> shared/psiu_params.svh
// register map, field positions and reset values of the sync unit
`ifndef PSIU_PARAMS_SVH
`define PSIU_PARAMS_SVH

`define PSIU_DATA_W          32
`define PSIU_ADDR_W          8

`define PSIU_OFF_CTRL        8'h00
`define PSIU_OFF_SYNC        8'h04
`define PSIU_OFF_PERIOD      8'h08
`define PSIU_OFF_START       8'h0c
`define PSIU_OFF_COUNT       8'h10
`define PSIU_OFF_MASK        8'h14
`define PSIU_OFF_INIT        8'h18
`define PSIU_OFF_STATUS      8'h1c
`define PSIU_OFF_PAIR        8'h20
`define PSIU_OFF_MATCH       8'h40

`define PSIU_CTRL_EXT_EN     0
`define PSIU_CTRL_INIT       1
`define PSIU_CTRL_POLICY     2
`define PSIU_CTRL_COUNTER_CLOCK_SELECT_LO    4
`define PSIU_CTRL_COUNTER_CLOCK_SELECT_HI    5

`define PSIU_SYNC_AT_MIN     0
`define PSIU_SYNC_AT_MAX     1
`define PSIU_SYNC_RELOAD     2
`define PSIU_SYNC_MASK       3
`define PSIU_SYNC_TRIG_LO    4
`define PSIU_SYNC_TRIG_HI    6
`define PSIU_SYNC_SWSTB      7

`define PSIU_STAT_PEND       0
`define PSIU_STAT_OUT_LO     8
`define PSIU_STAT_MASK_LO    16

`define PSIU_RST_PERIOD      16'hffff
`define PSIU_RST_ZERO        16'h0000
`define PSIU_HTRANS_NONSEQ   2'h2

`endif

// >>> shared/psiu_pkg.sv
// types shared by the sync and init unit
package psiu_pkg;

    typedef struct packed {
        logic [1:0] clk_sel;
        logic       policy;
        logic       ext_en;
    } psiu_ctrl_t;

    typedef struct packed {
        logic [2:0] hw_trig_en;
        logic       mask_sync;
        logic       reload;
        logic       at_max;
        logic       at_min;
    } psiu_sync_cfg_t;

    typedef struct packed {
        logic       valid;
        logic       write;
        logic [7:0] addr;
    } psiu_ahb_req_t;

endpackage : psiu_pkg

// >>> rtl/psiu_top.sv
// buffered update, counter reload, output mask and init logic of a pwm timer
`timescale 1ns/1ps
`include "psiu_params.svh"

module psiu_top
    import psiu_pkg::*;
#(
    parameter int NUM_CH  = 4,
    parameter int CNT_W   = 16,
    parameter int NUM_TRG = 3
)(
    // clock and reset
    input  wire logic                  CORE_CLK_I,
    input  wire logic                  RST_N_I,
    // ahb-lite slave
    input  wire logic                  HSEL_I,
    input  wire logic [31:0]           HADDR_I,
    input  wire logic [1:0]            HTRANS_I,
    input  wire logic                  HWRITE_I,
    input  wire logic [2:0]            HSIZE_I,
    input  wire logic [31:0]           HWDATA_I,
    input  wire logic                  HREADY_I,
    output logic      [31:0]           HRDATA_O,
    output logic                       HREADYOUT_O,
    output logic                       HRESP_O,
    // triggers from the rest of the timer
    input  wire logic [NUM_TRG-1:0]    HW_TRIG_I,
    // timer side
    output logic [CNT_W-1:0]           COUNTER_O,
    output logic [NUM_CH-1:0]          CH_O
);
    import psiu_pkg::*;

    localparam int NPAIR = NUM_CH / 2;

    psiu_ahb_req_t         req_q;
    psiu_ctrl_t            ctrl_q;
    psiu_sync_cfg_t        sync_q;
    logic [31:0]           rdata_q;
    logic [31:0]           rdata_d;
    logic [CNT_W-1:0]      period_buf_q;
    logic [CNT_W-1:0]      period_q;
    logic [CNT_W-1:0]      start_q;
    logic [CNT_W-1:0]      cnt_q;
    logic [CNT_W-1:0]      cnt_d;
    logic [NUM_CH-1:0]     mask_buf_q;
    logic [NUM_CH-1:0]     mask_q;
    logic [NUM_CH-1:0]     init_lvl_q;
    logic [NPAIR-1:0]      pair_sync_q;
    logic [NUM_CH-1:0]     out_q;
    logic [NUM_TRG-1:0]    trig_prev_q;
    logic                  pend_q;
    logic [CNT_W-1:0]      match_buf_q [NUM_CH];
    logic [CNT_W-1:0]      match_q     [NUM_CH];

    logic                  wr_en;
    logic                  wr_ctrl;
    logic                  wr_sync;
    logic                  hw_evt;
    logic                  sw_evt;
    logic                  any_evt;
    logic                  buf_evt;
    logic                  imm_mode;
    logic                  running;
    logic                  boundary;
    logic                  load_buf;
    logic                  cnt_reload;
    logic                  mask_load;
    logic                  init_stb;

    // zero wait states, always OKAY
    assign HREADYOUT_O = 1'b1;
    assign HRESP_O     = 1'b0;
    assign HRDATA_O    = rdata_q;
    assign COUNTER_O   = cnt_q;
    assign CH_O        = out_q & ~mask_q;

    always_ff @(posedge CORE_CLK_I or negedge RST_N_I)
    begin
        if (!RST_N_I)
        begin
            req_q <= '0;
        end
        else if (HREADY_I)
        begin
            req_q.valid <= HSEL_I && (HTRANS_I == `PSIU_HTRANS_NONSEQ);
            req_q.write <= HWRITE_I;
            req_q.addr  <= HADDR_I[`PSIU_ADDR_W-1:0];
        end
    end

    assign wr_en   = req_q.valid && req_q.write;
    assign wr_ctrl = wr_en && (req_q.addr == `PSIU_OFF_CTRL);
    assign wr_sync = wr_en && (req_q.addr == `PSIU_OFF_SYNC);

    // strobes are write-one and never stored
    assign sw_evt   = wr_sync && HWDATA_I[`PSIU_SYNC_SWSTB];
    assign init_stb = wr_ctrl && HWDATA_I[`PSIU_CTRL_INIT];

    // inputs are synchronous, so one stage of history is enough
    always_ff @(posedge CORE_CLK_I or negedge RST_N_I)
    begin
        if (!RST_N_I)
            trig_prev_q <= '0;
        else
            trig_prev_q <= HW_TRIG_I;
    end

    assign hw_evt  = |(HW_TRIG_I & ~trig_prev_q & sync_q.hw_trig_en);
    assign any_evt = hw_evt || sw_evt;

    // policy one hands buffered period and match loads to software only
    assign buf_evt  = ctrl_q.policy ? sw_evt : any_evt;
    assign imm_mode = !ctrl_q.policy && sync_q.reload;
    assign running  = (ctrl_q.clk_sel != 2'h0);

    // both selects set or both clear picks no boundary
    assign boundary = running &&
        ((sync_q.at_max && !sync_q.at_min && cnt_q >= period_q) ||
         (sync_q.at_min && !sync_q.at_max && cnt_q == start_q));

    assign load_buf = imm_mode ? any_evt
                               : (pend_q && boundary);

    // set wins: a trigger on the boundary cycle arms the next one
    always_ff @(posedge CORE_CLK_I or negedge RST_N_I)
    begin
        if (!RST_N_I)
            pend_q <= 1'b0;
        else
            pend_q <= (pend_q && !load_buf) || (buf_evt && !imm_mode);
    end

    always_ff @(posedge CORE_CLK_I or negedge RST_N_I)
    begin
        if (!RST_N_I)
        begin
            ctrl_q <= '0;
            sync_q <= '0;
        end
        else
        begin
            if (wr_ctrl)
            begin
                ctrl_q.ext_en  <= HWDATA_I[`PSIU_CTRL_EXT_EN];
                ctrl_q.policy  <= HWDATA_I[`PSIU_CTRL_POLICY];
                ctrl_q.clk_sel <=
                    HWDATA_I[`PSIU_CTRL_COUNTER_CLOCK_SELECT_HI:`PSIU_CTRL_COUNTER_CLOCK_SELECT_LO];
            end
            if (wr_sync)
            begin
                sync_q.at_min     <= HWDATA_I[`PSIU_SYNC_AT_MIN];
                sync_q.at_max     <= HWDATA_I[`PSIU_SYNC_AT_MAX];
                sync_q.reload     <= HWDATA_I[`PSIU_SYNC_RELOAD];
                sync_q.mask_sync  <= HWDATA_I[`PSIU_SYNC_MASK];
                sync_q.hw_trig_en <=
                    HWDATA_I[`PSIU_SYNC_TRIG_HI:`PSIU_SYNC_TRIG_LO];
            end
        end
    end

    always_ff @(posedge CORE_CLK_I or negedge RST_N_I)
    begin
        if (!RST_N_I)
        begin
            period_buf_q <= `PSIU_RST_PERIOD;
            start_q      <= `PSIU_RST_ZERO;
            mask_buf_q   <= '0;
            init_lvl_q   <= '0;
            pair_sync_q  <= '0;
        end
        else if (wr_en)
        begin
            unique case (req_q.addr)
                `PSIU_OFF_PERIOD: period_buf_q <= HWDATA_I[CNT_W-1:0];
                `PSIU_OFF_START:  start_q      <= HWDATA_I[CNT_W-1:0];
                `PSIU_OFF_MASK:   mask_buf_q   <= HWDATA_I[NUM_CH-1:0];
                `PSIU_OFF_INIT:   init_lvl_q   <= HWDATA_I[NUM_CH-1:0];
                `PSIU_OFF_PAIR:   pair_sync_q  <= HWDATA_I[NPAIR-1:0];
                default:          ;
            endcase
        end
    end

    // active period only moves on load_buf: a sync event in imm_mode, else the boundary that a sync event armed
    always_ff @(posedge CORE_CLK_I or negedge RST_N_I)
    begin
        if (!RST_N_I)
        begin
            period_q <= `PSIU_RST_PERIOD;
        end
        else if (load_buf)
        begin
            period_q <= period_buf_q;
        end
    end

    genvar ch;
    generate
        for (ch = 0; ch < NUM_CH; ch++)
        begin : g_ch
            always_ff @(posedge CORE_CLK_I or negedge RST_N_I)
            begin
                if (!RST_N_I)
                begin
                    match_buf_q[ch] <= `PSIU_RST_ZERO;
                end
                else if (wr_en && req_q.addr ==
                         8'(`PSIU_OFF_MATCH + 4 * ch))
                begin
                    match_buf_q[ch] <= HWDATA_I[CNT_W-1:0];
                end
            end

            // unsynced pairs follow their buffer one clock later
            always_ff @(posedge CORE_CLK_I or negedge RST_N_I)
            begin
                if (!RST_N_I)
                begin
                    match_q[ch] <= `PSIU_RST_ZERO;
                end
                else if (!pair_sync_q[ch / 2] ||
                         load_buf)
                begin
                    match_q[ch] <= match_buf_q[ch];
                end
            end

            always_ff @(posedge CORE_CLK_I or negedge RST_N_I)
            begin
                if (!RST_N_I)
                begin
                    out_q[ch] <= 1'b0;
                end
                else if (init_stb)
                begin
                    out_q[ch] <= init_lvl_q[ch];
                end
                else if (running)
                begin
                    out_q[ch] <= (cnt_q < match_q[ch]);
                end
            end
        end
    endgenerate

    // policy one leaves counter restarts to hardware triggers
    assign cnt_reload = sync_q.reload &&
                        (ctrl_q.policy ? hw_evt : any_evt);

    always_comb
    begin
        cnt_d = cnt_q;
        if (cnt_reload)
        begin
            cnt_d = start_q;
        end
        else if (running)
        begin
            // wrap on >= so a shrunk period cannot run away
            cnt_d = (cnt_q >= period_q) ? start_q
                                        : CNT_W'(cnt_q + 1'b1);
        end
    end

    always_ff @(posedge CORE_CLK_I or negedge RST_N_I)
    begin
        if (!RST_N_I)
            cnt_q <= `PSIU_RST_ZERO;
        else
            cnt_q <= cnt_d;
    end

    assign mask_load = !sync_q.mask_sync
                    || (!ctrl_q.policy && any_evt)
                    || (ctrl_q.policy && hw_evt);

    always_ff @(posedge CORE_CLK_I or negedge RST_N_I)
    begin
        if (!RST_N_I)
            mask_q <= '0;
        else if (mask_load)
            mask_q <= mask_buf_q;
    end

    // read data is caught in the address phase and held for the data phase
    always_comb
    begin
        rdata_d = '0;
        unique case (HADDR_I[`PSIU_ADDR_W-1:0])
            `PSIU_OFF_CTRL:
            begin
                rdata_d[`PSIU_CTRL_EXT_EN] = ctrl_q.ext_en;
                rdata_d[`PSIU_CTRL_POLICY] = ctrl_q.policy;
                rdata_d[`PSIU_CTRL_COUNTER_CLOCK_SELECT_HI:`PSIU_CTRL_COUNTER_CLOCK_SELECT_LO] =
                    ctrl_q.clk_sel;
            end
            `PSIU_OFF_SYNC:
            begin
                rdata_d[`PSIU_SYNC_AT_MIN] = sync_q.at_min;
                rdata_d[`PSIU_SYNC_AT_MAX] = sync_q.at_max;
                rdata_d[`PSIU_SYNC_RELOAD] = sync_q.reload;
                rdata_d[`PSIU_SYNC_MASK]   = sync_q.mask_sync;
                rdata_d[`PSIU_SYNC_TRIG_HI:`PSIU_SYNC_TRIG_LO] =
                    sync_q.hw_trig_en;
            end
            `PSIU_OFF_PERIOD: rdata_d[CNT_W-1:0]  = period_q;
            `PSIU_OFF_START:  rdata_d[CNT_W-1:0]  = start_q;
            `PSIU_OFF_COUNT:  rdata_d[CNT_W-1:0]  = cnt_q;
            `PSIU_OFF_MASK:   rdata_d[NUM_CH-1:0] = mask_buf_q;
            `PSIU_OFF_INIT:   rdata_d[NUM_CH-1:0] = init_lvl_q;
            `PSIU_OFF_PAIR:   rdata_d[NPAIR-1:0]  = pair_sync_q;
            `PSIU_OFF_STATUS:
            begin
                rdata_d[`PSIU_STAT_PEND] = pend_q;
                rdata_d[`PSIU_STAT_OUT_LO +: NUM_CH]  = CH_O;
                rdata_d[`PSIU_STAT_MASK_LO +: NUM_CH] = mask_q;
            end
            default:
            begin
                for (int i = 0; i < NUM_CH; i++)
                begin
                    if (HADDR_I[`PSIU_ADDR_W-1:0] ==
                        8'(`PSIU_OFF_MATCH + 4 * i))
                    begin
                        rdata_d[CNT_W-1:0] = match_q[i];
                    end
                end
            end
        endcase
    end

    always_ff @(posedge CORE_CLK_I or negedge RST_N_I)
    begin
        if (!RST_N_I)
        begin
            rdata_q <= '0;
        end
        else if (HREADY_I && HSEL_I && !HWRITE_I &&
                 HTRANS_I == `PSIU_HTRANS_NONSEQ)
        begin
            rdata_q <= rdata_d;
        end
    end

endmodule : psiu_top

// >>> tb/psiu_sync_assertions.sv
// port-level checks of the sync and init unit
`timescale 1ns/1ps
module psiu_sync_assertions
#(
    parameter int NUM_CH  = 4,
    parameter int CNT_W   = 16,
    parameter int NUM_TRG = 3
)(
    // clock, reset and bus
    input wire logic               CORE_CLK_I,
    input wire logic               RST_N_I,
    input wire logic               HSEL_I,
    input wire logic [31:0]        HADDR_I,
    input wire logic [1:0]         HTRANS_I,
    input wire logic               HWRITE_I,
    input wire logic [31:0]        HWDATA_I,
    input wire logic               HREADY_I,
    input wire logic               HREADYOUT_O,
    input wire logic               HRESP_O,
    // timer side
    input wire logic [NUM_TRG-1:0] HW_TRIG_I,
    input wire logic [CNT_W-1:0]   COUNTER_O,
    input wire logic [NUM_CH-1:0]  CH_O
);
    logic               wr_q;
    logic [7:0]         adr_q;
    logic [7:0]         ctl_q;
    logic [7:0]         syn_q;
    logic [CNT_W-1:0]   st_q;
    logic [NUM_CH-1:0]  msk_q;
    logic [NUM_CH-1:0]  ini_q;
    logic [NUM_TRG-1:0] trg_q;

    // shadow of the config, so checks need no internal probes
    always_ff @(posedge CORE_CLK_I or negedge RST_N_I)
    begin
        if (!RST_N_I)
            {wr_q, adr_q, trg_q} <= '0;
        else
        begin
            wr_q  <= HSEL_I && HREADY_I && HTRANS_I == 2'h2 && HWRITE_I;
            adr_q <= HADDR_I[7:0];
            trg_q <= HW_TRIG_I;
        end
    end

    always_ff @(posedge CORE_CLK_I or negedge RST_N_I)
    begin
        if (!RST_N_I)
            {ctl_q, syn_q, st_q, msk_q, ini_q} <= '0;
        else if (wr_q)
        begin
            case (adr_q)
                8'h00: ctl_q <= HWDATA_I[7:0];
                8'h04: syn_q <= HWDATA_I[7:0];
                8'h0c: st_q <= HWDATA_I[CNT_W-1:0];
                8'h14: msk_q <= HWDATA_I[NUM_CH-1:0];
                8'h18: ini_q <= HWDATA_I[NUM_CH-1:0];
                default: ;
            endcase
        end
    end

    wire hw_ev = |(HW_TRIG_I & ~trg_q & syn_q[4 +: NUM_TRG]);
    wire sw_ev = wr_q && adr_q == 8'h04 && HWDATA_I[7];
    wire ini_w = wr_q && adr_q == 8'h00 && HWDATA_I[1];
    wire stop  = ctl_q[5:4] == 2'h0;
    wire pol   = ctl_q[2];
    wire rl    = syn_q[2];
    wire ms    = syn_q[3];

    default clocking cb @(posedge CORE_CLK_I); endclocking
    default disable iff (!RST_N_I);

    property p_rl_any;
        (hw_ev || sw_ev) && rl && !pol |=> COUNTER_O == st_q;
    endproperty
    a_rl_any: assert property (p_rl_any) else $error("no reload");
    property p_rl_hw;
        hw_ev && rl && pol |=> COUNTER_O == st_q;
    endproperty
    a_rl_hw: assert property (p_rl_hw) else $error("no hw reload");
    property p_rl_sw;
        sw_ev && !hw_ev && rl && pol && stop |=> $stable(COUNTER_O);
    endproperty
    a_rl_sw: assert property (p_rl_sw) else $error("sw reload");
    property p_hold;
        stop && !hw_ev && !sw_ev |=> $stable(COUNTER_O);
    endproperty
    a_hold: assert property (p_hold) else $error("counter moved");
    property p_mask_now;
        !ms && $stable(syn_q) && $stable(msk_q) |-> (CH_O & msk_q) == '0;
    endproperty
    a_mask_now: assert property (p_mask_now) else $error("mask");
    property p_mask_trg;
        ms && (hw_ev || sw_ev && !pol) |=> (CH_O & msk_q) == '0;
    endproperty
    a_mask_trg: assert property (p_mask_trg) else $error("mask trg");
    property p_init;
        ini_w && msk_q == '0 && !ms |=> CH_O == ini_q;
    endproperty
    a_init: assert property (p_init) else $error("init levels");
    property p_bus;
        HREADYOUT_O && !HRESP_O;
    endproperty
    a_bus: assert property (p_bus) else $error("bus answer");

    c_sw: cover property (sw_ev && rl);
    c_hw: cover property (hw_ev && ms);
    c_init: cover property (ini_w);
endmodule : psiu_sync_assertions

bind psiu_top psiu_sync_assertions #(
    .NUM_CH(NUM_CH), .CNT_W(CNT_W), .NUM_TRG(NUM_TRG)
) u_chk (
    .CORE_CLK_I(CORE_CLK_I), .RST_N_I(RST_N_I), .HSEL_I(HSEL_I),
    .HADDR_I(HADDR_I), .HTRANS_I(HTRANS_I), .HWRITE_I(HWRITE_I),
    .HWDATA_I(HWDATA_I), .HREADY_I(HREADY_I),
    .HREADYOUT_O(HREADYOUT_O), .HRESP_O(HRESP_O),
    .HW_TRIG_I(HW_TRIG_I), .COUNTER_O(COUNTER_O), .CH_O(CH_O)
);

// >>> tb/psiu_top_tb.sv
// self-checking bench of the sync and init unit
`timescale 1ns/1ps
module psiu_top_tb;
    logic        clk    = 1'b0;
    logic        rst_n  = 1'b0;
    logic [1:0]  htrans = 2'h0;
    logic [31:0] haddr  = 32'h0;
    logic        hwrite = 1'b0;
    logic [31:0] hwdata = 32'h0;
    logic [2:0]  trig   = 3'h0;
    logic        rdy;
    logic        hresp;
    logic [31:0] rdata;
    logic [15:0] cnt;
    logic [3:0]  ch;
    logic [31:0] r;
    logic [31:0] seed   = 32'h6363;
    logic [15:0] mv [4];
    int          ti;
    int          n_errors = 0;
    int          checked  = 0;

    always #10 clk = ~clk;

    psiu_top dut (
        .CORE_CLK_I(clk), .RST_N_I(rst_n), .HSEL_I(1'b1),
        .HADDR_I(haddr), .HTRANS_I(htrans), .HWRITE_I(hwrite),
        .HSIZE_I(3'h2), .HWDATA_I(hwdata), .HREADY_I(rdy),
        .HRDATA_O(rdata), .HREADYOUT_O(rdy), .HRESP_O(hresp),
        .HW_TRIG_I(trig), .COUNTER_O(cnt), .CH_O(ch)
    );

    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction : lfsr

    // inactive level of a masked channel is 0
    function automatic logic [15:0] masked(input logic [3:0] m);
        return {12'h0, 4'hf & ~m};
    endfunction : masked

    task automatic xfer(input logic w, input logic [7:0] a,
                        input logic [31:0] d);
        htrans <= 2'h2;
        haddr  <= {24'h0, a};
        hwrite <= w;
        do @(posedge clk); while (rdy !== 1'b1);
        htrans <= 2'h0;
        hwdata <= d;
        do @(posedge clk); while (rdy !== 1'b1);
        r = rdata;
    endtask : xfer

    // idle edge first: a read right after a write sees the old value of a match or mask copy that follows its buffer one clock later
    task automatic chk_reg(input logic [7:0] a, input logic [31:0] e);
        @(posedge clk);
        xfer(1'b0, a, 32'h0);
        checked++;
        if (r !== e)
        begin
            n_errors++;
            $display("unexpected reg %h: exp %h got %h", a, e, r);
        end
    endtask : chk_reg

    task automatic chk_pin(input logic s, input logic [15:0] e);
        logic [15:0] g;
        repeat (2) @(negedge clk);
        g = s ? {12'h0, ch} : cnt;
        checked++;
        if (g !== e)
        begin
            n_errors++;
            $display("unexpected pin %0d: exp %h got %h", s, e, g);
        end
        @(posedge clk);
    endtask : chk_pin

    task automatic pulse(input int i);
        trig <= 3'h1 << i;
        repeat (2) @(posedge clk);
        trig <= 3'h0;
        repeat (2) @(posedge clk);
    endtask : pulse

    task automatic report_and_stop();
        $display("checks %0d errors %0d", checked, n_errors);
        if (n_errors == 0 && checked > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask : report_and_stop

    initial
    begin
        repeat (3000) @(posedge clk);
        n_errors++;
        report_and_stop();
    end

    initial
    begin
        repeat (8) @(posedge clk);
        rst_n <= 1'b1;
        chk_reg(8'h08, 32'hffff);
        chk_reg(8'h30, 32'h0);
        xfer(1'b1, 8'h08, 32'ha);
        chk_reg(8'h08, 32'hffff);
        xfer(1'b1, 8'h0c, 32'h3);
        xfer(1'b1, 8'h04, 32'h04);
        xfer(1'b1, 8'h04, 32'h84);
        chk_reg(8'h08, 32'ha);
        chk_pin(1'b0, 16'h3);
        // max boundary: pending until the running counter wraps
        xfer(1'b1, 8'h08, 32'h14);
        xfer(1'b1, 8'h04, 32'h12);
        pulse(0);
        chk_reg(8'h08, 32'ha);
        chk_reg(8'h1c, 32'h1);
        xfer(1'b1, 8'h00, 32'h10);
        repeat (20) @(posedge clk);
        chk_reg(8'h08, 32'h14);
        xfer(1'b1, 8'h08, 32'h1e);
        repeat (45) @(posedge clk);
        chk_reg(8'h08, 32'h14);
        // policy one: hardware edge must not arm buffered loads
        xfer(1'b1, 8'h00, 32'h14);
        xfer(1'b1, 8'h04, 32'h11);
        xfer(1'b1, 8'h08, 32'hc);
        pulse(0);
        repeat (25) @(posedge clk);
        chk_reg(8'h08, 32'h14);
        xfer(1'b1, 8'h04, 32'h91);
        repeat (25) @(posedge clk);
        chk_reg(8'h08, 32'hc);
        xfer(1'b1, 8'h00, 32'h0);
        xfer(1'b1, 8'h20, 32'h1);
        for (int i = 0; i < 4; i++)
        begin
            seed = lfsr(seed);
            mv[i] = seed[15:0];
            xfer(1'b1, 8'h40 + 8'(4 * i), {16'h0, mv[i]});
        end
        ti = int'(seed[7:0]) % 3;
        xfer(1'b1, 8'h04, 32'h04);
        // hardware trigger only: no software strobe in this scenario
        xfer(1'b1, 8'h04, 32'h04 | (32'h10 << ti));
        chk_reg(8'h48, {16'h0, mv[2]});
        chk_reg(8'h40, 32'h0);
        pulse(ti);
        chk_reg(8'h40, {16'h0, mv[0]});
        chk_reg(8'h44, {16'h0, mv[1]});
        chk_pin(1'b0, 16'h3);
        xfer(1'b1, 8'h00, 32'h04);
        xfer(1'b1, 8'h0c, 32'h5);
        xfer(1'b1, 8'h04, 32'h14);
        pulse(1);
        xfer(1'b1, 8'h04, 32'h94);
        chk_pin(1'b0, 16'h3);
        pulse(0);
        chk_pin(1'b0, 16'h5);
        xfer(1'b1, 8'h18, 32'hf);
        // extended enable set and counter stopped in the init write
        xfer(1'b1, 8'h00, 32'h03);
        chk_pin(1'b1, 16'hf);
        xfer(1'b1, 8'h14, 32'h5);
        chk_pin(1'b1, masked(4'h5));
        xfer(1'b1, 8'h04, 32'h18);
        xfer(1'b1, 8'h14, 32'h3);
        chk_pin(1'b1, masked(4'h5));
        xfer(1'b1, 8'h04, 32'h98);
        chk_pin(1'b1, masked(4'h3));
        xfer(1'b1, 8'h00, 32'h04);
        xfer(1'b1, 8'h14, 32'h0);
        xfer(1'b1, 8'h04, 32'h98);
        chk_pin(1'b1, masked(4'h3));
        pulse(0);
        chk_pin(1'b1, masked(4'h0));
        report_and_stop();
    end
endmodule : psiu_top_tb
